/* rtl/locd_pkg.sv */
// constants for the logic output condition driver
// assumes a 100 MHz clock and an AHB-Lite register bus with 32-bit data
package locd_pkg;
	localparam int NPIN = 20;
	localparam logic [4:0] PIN_WILD = 5'h1f;
	// byte offsets of the registers
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_PATTERN = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_POLARITY = 8'h0c;
	localparam logic [7:0] OFF_DIRECT = 8'h10;
	localparam logic [7:0] OFF_REPORT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// command word fields
	localparam int CMD_PIN_LSB = 0;
	localparam int CMD_KIND_BIT = 5;
	localparam int CMD_SRC_LSB = 6;
	localparam int CMD_DEL_BIT = 9;
	// status word fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_CODE_LSB = 8;
	localparam logic [7:0] ERR_BAD_COND = 8'h4a;
	// pattern position codes, three bits each
	localparam logic [2:0] PC_DONTCARE = 3'h0;
	localparam logic [2:0] PC_ZERO = 3'h1;
	localparam logic [2:0] PC_ONE = 3'h2;
	localparam logic [2:0] PC_MINUS = 3'h3;
	localparam logic [2:0] PC_PLUS = 3'h4;
	// status sources
	localparam logic [2:0] SRC_GAIN = 3'h0;
	localparam logic [2:0] SRC_OUT_MUTE = 3'h1;
	localparam logic [2:0] SRC_IN_MUTE = 3'h2;
	localparam logic [2:0] SRC_NOISE = 3'h3;
	// report enable write values
	localparam logic [1:0] RPT_OFF = 2'h0;
	localparam logic [1:0] RPT_ON = 2'h1;
	localparam logic [1:0] RPT_TOGGLE = 2'h2;
	// values after reset
	localparam logic [NPIN-1:0] MASK_RST = 20'hfffff;
	localparam logic [NPIN-1:0] POL_RST = 20'hfffff;
	localparam logic [NPIN-1:0] LVL_RST = 20'h00000;
	localparam logic RPT_EN_RST = 1'b0;
	// persistent store write time
	localparam int CLK_PERIOD_NS = 10;
	localparam int NVM_WRITE_NS = 10000;
	localparam int NVM_CYC = (NVM_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NVM_CW = 10;
	localparam logic [NVM_CW-1:0] NVM_LAST = NVM_CW'(NVM_CYC - 1);
endpackage

/* rtl/locd_top.sv */
// logic output condition driver: 20 pins driven by channel status patterns
// assumes clk synchronous inputs, one AHB-Lite master, word accesses only
`timescale 1ns/1ns
`default_nettype none

module locd_top
	import locd_pkg::*;
#(
	parameter int NCH = 8
) (
	input  wire logic           clk,                 // 100 MHz clock
	input  wire logic           nrst,                // async reset, active low
	input  wire logic           hsel,                // slave select
	input  wire logic [31:0]    haddr,               // byte address
	input  wire logic [1:0]     htrans,              // transfer type
	input  wire logic           hwrite,              // write when high
	input  wire logic [2:0]     hsize,               // word only
	input  wire logic [31:0]    hwdata,              // write data
	input  wire logic           hready,              // bus ready
	output logic                hreadyout,           // slave ready
	output logic                hresp,               // always okay
	output logic [31:0]         hrdata,              // read data
	input  wire logic [NCH-1:0] gain_control_status, // per-channel gain control enable
	input  wire logic [NCH-1:0] output_mute_status,  // per-channel output mute
	input  wire logic [NCH-1:0] input_mute_status,   // per-channel input mute
	input  wire logic [NCH-1:0] noise_cancel_status, // per-channel noise cancel enable
	output logic [NPIN-1:0]     output_pins,         // pin levels, bit 0 is output one
	output logic                report_valid,        // one-cycle change report
	output logic [NPIN-1:0]     report_levels        // pin levels in the report
);
	localparam int PW = 3 * NCH;
	localparam int CW = 3 + PW;

	if (NCH < 1 || NCH > 10) begin : g_chk
		$error("NCH must be 1 to 10 so a pattern fits one word");
	end

	typedef struct packed {
		logic [NPIN-1:0][1:0][CW-1:0] cond;
		logic [PW-1:0]                pat;
		logic [NPIN-1:0]              mask;
		logic [NPIN-1:0]              pol;
		logic [NPIN-1:0]              lvl;
		logic                         rpt_en;
		logic                         rpt_vld;
		logic [NPIN-1:0]              rpt_data;
		logic                         busy;
		logic                         done;
		logic                         err;
		logic [NVM_CW-1:0]            cnt;
		logic                         rdy;
		logic                         resp;
		logic [31:0]                  rdata;
		logic                         wr;
		logic                         rd;
		logic [7:0]                   addr;
	} locd_state_t;

	locd_state_t q_reg;
	locd_state_t d_next;
	logic        rst_meta_reg;
	logic        rst_n_sync;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync <= rst_meta_reg;
		end
	end

	// status comes in as an argument: a continuous assignment only re-evaluates on its operands
	function automatic logic [NCH-1:0] src_vec(input logic [1:0] src, input logic [3:0][NCH-1:0] all);
		case (src)
			SRC_GAIN[1:0]:     src_vec = all[0];
			SRC_OUT_MUTE[1:0]: src_vec = all[1];
			SRC_IN_MUTE[1:0]:  src_vec = all[2];
			default:           src_vec = all[3];
		endcase
	endfunction

	// one stored condition: valid, source, pattern
	function automatic logic cond_true(input logic [CW-1:0] c, input logic [3:0][NCH-1:0] all);
		logic [NCH-1:0] sv;
		logic           ok;
		logic           grp;
		logic           hit;
		sv = src_vec(c[PW+1:PW], all);
		ok = c[CW-1];
		grp = 1'b0;
		hit = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			case (c[3*i +: 3])
				PC_ZERO:  if (sv[i]) ok = 1'b0;
				PC_ONE:   if (!sv[i]) ok = 1'b0;
				PC_MINUS: begin
					grp = 1'b1;
					if (!sv[i]) hit = 1'b1;
				end
				PC_PLUS:  begin
					grp = 1'b1;
					if (sv[i]) hit = 1'b1;
				end
				default:  ;
			endcase
		end
		cond_true = ok && (!grp || hit);
	endfunction

	function automatic logic pat_ok(input logic [PW-1:0] p);
		pat_ok = 1'b1;
		for (int i = 0; i < NCH; i++) begin
			if (p[3*i +: 3] > PC_PLUS) pat_ok = 1'b0;
		end
	endfunction

	logic [NPIN-1:0] act_vec;
	logic [NPIN-1:0] deact_vec;
	logic [NPIN-1:0] assigned_vec;

	// index is the source code of a condition
	logic [3:0][NCH-1:0] st_all;
	assign st_all = {noise_cancel_status, input_mute_status, output_mute_status, gain_control_status};

	// every condition is evaluated each cycle against the live status
	for (genvar g = 0; g < NPIN; g++) begin : g_eval
		assign act_vec[g] = cond_true(q_reg.cond[g][0], st_all);
		assign deact_vec[g] = cond_true(q_reg.cond[g][1], st_all);
		assign assigned_vec[g] = q_reg.cond[g][0][CW-1] | q_reg.cond[g][1][CW-1];
	end

	logic       wr_cmd;
	logic       wr_dir;
	logic       wr_rpt;
	logic       cmd_bad;
	logic [4:0] cmd_pin;
	logic       cmd_kind;
	logic [2:0] cmd_src;
	logic       cmd_del;

	always_comb begin
		cmd_pin = hwdata[CMD_PIN_LSB +: 5];
		cmd_kind = hwdata[CMD_KIND_BIT];
		cmd_src = hwdata[CMD_SRC_LSB +: 3];
		cmd_del = hwdata[CMD_DEL_BIT];
		// commands are refused while a persistent write is still running
		wr_cmd = q_reg.wr && q_reg.addr == OFF_CMD && !q_reg.busy;
		wr_dir = q_reg.wr && q_reg.addr == OFF_DIRECT;
		wr_rpt = q_reg.wr && q_reg.addr == OFF_REPORT;
		if (cmd_del) begin
			cmd_bad = cmd_pin >= 5'(NPIN) && cmd_pin != PIN_WILD;
		end else begin
			cmd_bad = cmd_pin >= 5'(NPIN) || cmd_src > SRC_NOISE || !pat_ok(q_reg.pat);
		end
	end

	always_comb begin
		d_next = q_reg;
		d_next.rpt_vld = 1'b0;
		d_next.rdy = 1'b1;
		d_next.resp = 1'b0;
		d_next.wr = 1'b0;
		d_next.rd = 1'b0;
		// reads take one wait state so a preceding write is always seen
		if (q_reg.rd) begin
			if (q_reg.addr == OFF_PATTERN) begin
				d_next.rdata = 32'(q_reg.pat);
			end else if (q_reg.addr == OFF_MASK) begin
				d_next.rdata = 32'(q_reg.mask);
			end else if (q_reg.addr == OFF_POLARITY) begin
				d_next.rdata = 32'(q_reg.pol);
			end else if (q_reg.addr == OFF_DIRECT) begin
				d_next.rdata = 32'(q_reg.lvl);
			end else if (q_reg.addr == OFF_REPORT) begin
				d_next.rdata = 32'(q_reg.rpt_en);
			end else if (q_reg.addr == OFF_STATUS) begin
				d_next.rdata = 32'h0;
				d_next.rdata[ST_BUSY_BIT] = q_reg.busy;
				d_next.rdata[ST_DONE_BIT] = q_reg.done;
				d_next.rdata[ST_ERR_BIT] = q_reg.err;
				if (q_reg.err) d_next.rdata[ST_CODE_LSB +: 8] = ERR_BAD_COND;
			end else begin
				d_next.rdata = 32'h0;
			end
		end
		if (hsel && htrans[1] && hready) begin
			d_next.addr = haddr[7:0];
			d_next.wr = hwrite;
			d_next.rd = !hwrite;
			d_next.rdy = hwrite;
		end
		if (q_reg.wr) begin
			if (q_reg.addr == OFF_PATTERN) d_next.pat = hwdata[PW-1:0];
			if (q_reg.addr == OFF_MASK) d_next.mask = hwdata[NPIN-1:0];
			if (q_reg.addr == OFF_POLARITY) d_next.pol = hwdata[NPIN-1:0];
		end
		if (wr_rpt) begin
			case (hwdata[1:0])
				RPT_OFF:    d_next.rpt_en = 1'b0;
				RPT_ON:     d_next.rpt_en = 1'b1;
				RPT_TOGGLE: d_next.rpt_en = !q_reg.rpt_en;
				default:    ;
			endcase
		end
		// persistent store timer; done is the delayed acknowledgement
		if (q_reg.busy) begin
			if (q_reg.cnt == '0) begin
				d_next.busy = 1'b0;
				d_next.done = 1'b1;
			end else begin
				d_next.cnt = q_reg.cnt - 1'b1;
			end
		end
		if (wr_cmd) begin
			d_next.done = 1'b0;
			d_next.err = cmd_bad;
			if (!cmd_bad) begin
				d_next.busy = 1'b1;
				d_next.cnt = NVM_LAST;
				if (cmd_del && cmd_pin == PIN_WILD) begin
					d_next.cond = '0;
				end else if (cmd_del) begin
					d_next.cond[cmd_pin] = '0;
				end else begin
					d_next.cond[cmd_pin][cmd_kind] = {1'b1, cmd_src[1:0], q_reg.pat};
				end
			end
		end
		for (int i = 0; i < NPIN; i++) begin
			if (wr_dir && (!q_reg.mask[i] || !assigned_vec[i])) begin
				d_next.lvl[i] = hwdata[i];
			end else if (q_reg.mask[i]) begin
				if (act_vec[i]) begin
					d_next.lvl[i] = q_reg.pol[i];
				end else if (deact_vec[i]) begin
					d_next.lvl[i] = !q_reg.pol[i];
				end
			end
		end
		if (q_reg.rpt_en && d_next.lvl != q_reg.lvl) begin
			d_next.rpt_vld = 1'b1;
			d_next.rpt_data = d_next.lvl;
		end
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			q_reg <= '0;
			q_reg.mask <= MASK_RST;
			q_reg.pol <= POL_RST;
			q_reg.lvl <= LVL_RST;
			q_reg.rpt_en <= RPT_EN_RST;
			q_reg.rdy <= 1'b1;
		end else begin
			q_reg <= d_next;
		end
	end

	assign hreadyout = q_reg.rdy;
	assign hresp = q_reg.resp;
	assign hrdata = q_reg.rdata;
	assign output_pins = q_reg.lvl;
	assign report_valid = q_reg.rpt_vld;
	assign report_levels = q_reg.rpt_data;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_sync);

	a_act_level: assert property (!wr_dir |=>
		($past(act_vec & q_reg.mask) & (q_reg.lvl ^ $past(q_reg.pol))) == '0)
		else $error("activated pin not at active level");
	a_deact_level: assert property (!wr_dir |=>
		($past(~act_vec & deact_vec & q_reg.mask) & ~(q_reg.lvl ^ $past(q_reg.pol))) == '0)
		else $error("deactivated pin not at inactive level");
	a_mask_freeze: assert property (!wr_dir |=> ((q_reg.lvl ^ $past(q_reg.lvl)) & ~$past(q_reg.mask)) == '0)
		else $error("masked pin changed without direct write");
	a_idle_hold: assert property (!wr_dir |=>
		((q_reg.lvl ^ $past(q_reg.lvl)) & $past(~act_vec & ~deact_vec)) == '0)
		else $error("pin changed with no condition true");
	a_direct_set: assert property (wr_dir |=>
		((q_reg.lvl ^ $past(hwdata[NPIN-1:0])) & $past(~q_reg.mask | ~assigned_vec)) == '0)
		else $error("direct write not applied");
	a_report_fire: assert property (q_reg.rpt_vld == ($past(q_reg.rpt_en) && q_reg.lvl != $past(q_reg.lvl)))
		else $error("report does not match pin change");
	a_report_data: assert property (q_reg.rpt_vld |-> q_reg.rpt_data == q_reg.lvl)
		else $error("report carries wrong levels");
	a_bad_cmd: assert property (wr_cmd && cmd_bad |=> q_reg.err && !q_reg.busy && $stable(q_reg.cond))
		else $error("invalid condition was accepted");
	a_store_busy: assert property (wr_cmd && !cmd_bad |=> q_reg.busy && !q_reg.done ##1 q_reg.busy [*8])
		else $error("store did not hold busy");
	a_store_done: assert property ($fell(q_reg.busy) |-> q_reg.done)
		else $error("store ended without acknowledgement");
	a_delete_all: assert property (wr_cmd && !cmd_bad && cmd_del && cmd_pin == PIN_WILD |=> assigned_vec == '0)
		else $error("wildcard delete left a condition");
	a_rpt_toggle: assert property (wr_rpt && hwdata[1:0] == RPT_TOGGLE |=> q_reg.rpt_en != $past(q_reg.rpt_en))
		else $error("report enable did not toggle");
	a_delete_one: assert property (wr_cmd && !cmd_bad && cmd_del && cmd_pin != PIN_WILD |=>
		!assigned_vec[$past(cmd_pin)])
		else $error("pin delete left a condition");
	a_assign_stored: assert property (wr_cmd && !cmd_bad && !cmd_del |=> assigned_vec[$past(cmd_pin)])
		else $error("condition was not stored");
	a_bad_source: assert property (wr_cmd && !cmd_del && cmd_src > SRC_NOISE |=> q_reg.err)
		else $error("unknown status source accepted");
	a_rpt_on: assert property (wr_rpt && hwdata[1:0] == RPT_ON |=> q_reg.rpt_en)
		else $error("report enable not set");
	a_rpt_off: assert property (wr_rpt && hwdata[1:0] == RPT_OFF |=> !q_reg.rpt_en)
		else $error("report enable not cleared");
	a_report_quiet: assert property (!q_reg.rpt_en |=> !q_reg.rpt_vld)
		else $error("report sent while reporting off");
	a_cond_hold: assert property (wr_dir |=>
		((q_reg.lvl ^ $past(q_reg.lvl)) & $past(q_reg.mask & assigned_vec & ~act_vec & ~deact_vec)) == '0)
		else $error("direct write overrode an assigned pin");
	a_cond_wins: assert property (wr_dir |=>
		($past(q_reg.mask & act_vec) & (q_reg.lvl ^ $past(q_reg.pol))) == '0)
		else $error("direct write beat an active condition");
	a_store_idle: assert property (q_reg.busy |-> !q_reg.done)
		else $error("acknowledged while store still running");

	c_report: cover property (q_reg.rpt_vld);
	c_direct: cover property (wr_dir && (q_reg.mask & assigned_vec) != '0);
	c_unmask: cover property ($rose(q_reg.mask[0]) ##1 $changed(q_reg.lvl[0]));
	c_error: cover property (wr_cmd && cmd_bad);
	c_done: cover property ($fell(q_reg.busy));
endmodule

`default_nettype wire

/* testbench/locd_ctrl_model.sv */
// control system model: AHB-Lite master that programs the output driver
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/1ns
`default_nettype none
module locd_ctrl_model
	import locd_pkg::*;
(
	input  wire logic        clk,    // bus clock
	input  wire logic        hready, // slave ready
	input  wire logic [31:0] hrdata, // read data
	output logic             hsel,   // slave select
	output logic [31:0]      haddr,  // byte address
	output logic [1:0]       htrans, // idle or nonseq
	output logic             hwrite, // write when high
	output logic [2:0]       hsize,  // always a word
	output logic [31:0]      hwdata  // write data
);
	int n_late; // waits that ran out
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_late = 0;
	end
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1)
			n_late++;
	endtask
	// call just after a rising edge; returns just after the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hwdata <= ~hwdata; // a stale data bus must not look like fresh data
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d; // patterns go out whole, all channels at once
		wait_ready();
		q = hrdata;
	endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the logic output condition driver
// assumes the control system model as bus master and the bench as status source
`timescale 1ns/1ns
`default_nettype none
module tb;
	import locd_pkg::*;
	localparam int NCH = 8;
	localparam logic [1:0] RPT_W [6] = '{RPT_ON, RPT_TOGGLE, RPT_TOGGLE, 2'h3, RPT_OFF, RPT_ON};
	localparam logic [5:0] RPT_RD = 6'h2d;
	logic            clk;
	logic            nrst;
	logic            hsel;
	logic [31:0]     haddr;
	logic [1:0]      htrans;
	logic            hwrite;
	logic [2:0]      hsize;
	logic [31:0]     hwdata;
	logic            hreadyout;
	logic            hresp;
	logic [31:0]     hrdata;
	logic [NCH-1:0]  st [4]; // gain, output mute, input mute, noise cancel
	logic [NPIN-1:0] output_pins;
	logic            report_valid;
	logic [NPIN-1:0] report_levels;
	logic [NPIN-1:0] rep_seen;
	logic [31:0]     q;
	int              n_rep;
	int              n0;
	int              n_errors;
	int              comparisons;
	time             t0;
	locd_ctrl_model ctrl (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	locd_top #(.NCH(NCH)) dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .gain_control_status(st[0]), .output_mute_status(st[1]),
		.input_mute_status(st[2]), .noise_cancel_status(st[3]), .output_pins(output_pins),
		.report_valid(report_valid), .report_levels(report_levels));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk)
		if (report_valid === 1'b1) begin
			n_rep <= n_rep + 1;
			rep_seen <= report_levels;
		end
	task automatic give_verdict();
		n_errors += ctrl.n_late;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		ctrl.xfer(w, a, d, q);
		if (ctrl.n_late != 0)
			give_verdict();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		check("register read", e, q);
	endtask
	// three edges cover the one-cycle evaluation with margin; k is the expected report count
	task automatic expect_pins(input logic [NPIN-1:0] e, input int k);
		repeat (3) @(posedge clk);
		check("output pins", {12'h0, e}, {12'h0, output_pins});
		check("report count", 32'(k), 32'(n_rep - n0));
		if (k > 0)
			check("report levels", {12'h0, e}, {12'h0, rep_seen});
		n0 = n_rep;
	endtask
	task automatic cmd(input logic [31:0] c, input logic bad);
		int n;
		t0 = $time;
		wr(OFF_CMD, c);
		if (!bad)
			wr(OFF_CMD, 32'h14); // refused while the store runs
		rd(OFF_STATUS, bad ? {16'h0, ERR_BAD_COND, 8'h04} : 32'h1);
		n = 0;
		do begin
			xf(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (q === 32'h1 && n < 500);
		check("command status", bad ? {16'h0, ERR_BAD_COND, 8'h04} : 32'h2, q);
		if (q === 32'h1)
			give_verdict();
		if (!bad)
			check("store time", 32'h1, 32'(($time - t0) / 10 >= NVM_CYC && ($time - t0) / 10 <= NVM_CYC + 12));
	endtask
	initial begin
		#1000000;
		n_errors++;
		give_verdict();
	end
	initial begin
		nrst = 1'b0;
		for (int j = 0; j < 4; j++)
			st[j] = '0;
		n_rep = 0;
		n0 = 0;
		n_errors = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFF_MASK, {12'h0, MASK_RST});
		rd(OFF_POLARITY, {12'h0, POL_RST});
		rd(OFF_STATUS, 32'h0);
		rd(OFF_CMD, 32'h0);
		wr(8'h1c, 32'hffffffff);
		rd(8'h1c, 32'h0);
		wr(OFF_DIRECT, 32'h000a5);
		expect_pins(20'h000a5, 0);
		rd(OFF_DIRECT, 32'h000a5);
		for (int i = 0; i < 6; i++) begin
			wr(OFF_REPORT, {30'h0, RPT_W[i]});
			rd(OFF_REPORT, {31'h0, RPT_RD[i]});
		end
		wr(OFF_PATTERN, 32'h0);
		cmd(32'h20, 1'b0);
		expect_pins(20'h000a4, 1);
		wr(OFF_PATTERN, {29'h0, PC_ONE});
		for (int s = 0; s < 4; s++) begin
			cmd({23'h0, 3'(s), 6'h00}, 1'b0);
			for (int j = 0; j < 4; j++)
				st[j] <= (j == s) ? 8'h00 : 8'h01;
			expect_pins(20'h000a4, 0);
			st[s] <= 8'h01;
			expect_pins(20'h000a5, 1);
			for (int j = 0; j < 4; j++)
				st[j] <= 8'h00;
			expect_pins(20'h000a4, 1);
		end
		wr(OFF_PATTERN, {26'h0, PC_MINUS, PC_PLUS});
		cmd(32'h3, 1'b0);
		expect_pins(20'h000ac, 1);
		wr(OFF_PATTERN, {26'h0, PC_ONE, PC_ZERO});
		cmd(32'h23, 1'b0);
		st[0] <= 8'h02;
		expect_pins(20'h000a4, 1);
		st[0] <= 8'hfe;
		expect_pins(20'h000a4, 0);
		st[0] <= 8'hff;
		expect_pins(20'h000ac, 1);
		wr(OFF_PATTERN, {23'h0, PC_ONE, 6'h00});
		cmd(32'h89, 1'b0);
		wr(OFF_PATTERN, {23'h0, PC_ZERO, 6'h00});
		cmd(32'ha9, 1'b0);
		st[2] <= 8'h04;
		expect_pins(20'h002ac, 1);
		st[2] <= 8'h00;
		@(posedge clk);
		#1 check("pin one cycle on", 32'h0, {31'h0, output_pins[9]});
		expect_pins(20'h000ac, 1);
		st[2] <= 8'h04;
		expect_pins(20'h002ac, 1);
		wr(OFF_DIRECT, 32'h0);
		expect_pins(20'h00208, 1);
		cmd(32'h109, 1'b1);
		cmd(32'h14, 1'b1);
		wr(OFF_PATTERN, 32'h5);
		rd(OFF_PATTERN, 32'h5);
		cmd(32'h0, 1'b1);
		cmd(32'h214, 1'b1);
		expect_pins(20'h00208, 0);
		wr(OFF_MASK, 32'hffdff);
		st[2] <= 8'h00;
		expect_pins(20'h00208, 0);
		wr(OFF_DIRECT, 32'h0);
		expect_pins(20'h00008, 1);
		st[2] <= 8'h04;
		expect_pins(20'h00008, 0);
		wr(OFF_MASK, 32'hfffff);
		expect_pins(20'h00208, 1);
		wr(OFF_POLARITY, 32'hffdff);
		expect_pins(20'h00008, 1);
		wr(OFF_POLARITY, 32'hfffff);
		expect_pins(20'h00208, 1);
		cmd(32'h203, 1'b0);
		st[0] <= 8'h02;
		expect_pins(20'h00208, 0);
		cmd(32'h21f, 1'b0);
		st[2] <= 8'h00;
		expect_pins(20'h00208, 0);
		wr(OFF_DIRECT, 32'h12345);
		expect_pins(20'h12345, 1);
		check("response", 32'h0, {31'h0, hresp});
		give_verdict();
	end
endmodule
`default_nettype wire
